/* bench/tmkd_matrix_model.sv */
// Behavioural model of the key electrode matrix and the shared sampling capacitor
`timescale 1ns/1ps
module tmkd_matrix_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  drive_line_i,
  input  wire logic        transfer_switch_i,
  input  wire logic        cap_reset_switch_i,
  input  wire logic [15:0] burst_len_i [4],
  output logic             cap_at_ref_o
);
  logic [15:0] charge_r;
  logic [3:0]  drive_prev_r;
  logic [1:0]  key_r;
  // ==========================================
  // Capacitor charge, counted in transfer cycles
  always_ff @(posedge clk_i) begin
    drive_prev_r <= drive_line_i;
    if (rst_i || cap_reset_switch_i) begin
      charge_r <= 16'h0000; // Discharged while reset switch closed
    end else if (transfer_switch_i && |(drive_prev_r & ~drive_line_i)) begin
      charge_r <= charge_r + 16'h0001; // Drive falls with transfer closed
    end
  end
  // Key whose electrode is being driven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_r <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (drive_line_i[i]) begin
          key_r <= 2'(i);
        end
      end
    end
  end
  // Comparator against burst-end level; length per key set by the bench
  assign cap_at_ref_o = !cap_reset_switch_i && (charge_r >= burst_len_i[key_r]);
endmodule

/* bench/tmkd_tb_top.sv */
// Self-checking testbench of the touch matrix key detector
`timescale 1ns/1ps
module tmkd_tb_top;
  import tmkd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cap_at_ref;
  logic        roll_opt = 1'b1;
  logic        tmo_opt = 1'b1;
  logic [3:0]  drive;
  logic        prechg;
  logic        xfer;
  logic        cap_rst;
  logic [3:0]  key_out;
  logic [15:0] lens [4] = '{16'h0024, 16'h0024, 16'h0024, 16'h0024};
  logic [1:0]  last_key = 2'h3;
  logic        cap_prev = 1'b0;
  int          mismatches = 0;
  int          num_checks = 0;
  // ==========================================
  // Clock and design under test
  always #10 clk = ~clk;
  tmkd_top #(.SEC_LAST(26'h000_03E7)) uut (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .CAP_AT_REF_I(cap_at_ref),
    .ROLLOVER_OPTION_INPUT_I(roll_opt), .TIMEOUT_OPTION_INPUT_I(tmo_opt),
    .DRIVE_LINE_O(drive), .PRECHARGE_SWITCH_O(prechg), .TRANSFER_SWITCH_O(xfer),
    .CAP_RESET_SWITCH_O(cap_rst), .KEY_OUT_O(key_out));
  tmkd_matrix_model partner (
    .clk_i(clk), .rst_i(rst), .drive_line_i(drive), .transfer_switch_i(xfer),
    .cap_reset_switch_i(cap_rst), .burst_len_i(lens), .cap_at_ref_o(cap_at_ref));
  // ==========================================
  // Comparison and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Switch sequencing and scan order watched every cycle
  always @(negedge clk) begin
    if (!rst) begin
      check(16'($countones(drive) > 1), 16'h0000);
      check(16'(cap_rst && (prechg || xfer || |drive)), 16'h0000);
      check(16'(|drive && !prechg && !xfer), 16'h0000);
      check(16'(prechg && xfer), 16'h0000);
      for (int i = 0; i < 4; i++) begin
        if (drive[i] && 2'(i) != last_key) begin
          check(16'(i), 16'(2'(last_key + 2'h1)));
          last_key = 2'(i);
        end
      end
    end
  end
  // Wait for n starts of a burst, bounded
  task automatic wait_bursts(input int n);
    int seen;
    seen = 0;
    for (int c = 0; c < n * 6000 && seen < n; c++) begin
      @(negedge clk);
      if (cap_rst && !cap_prev) begin
        seen++;
      end
      cap_prev = cap_rst;
    end
    if (seen < n) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, n);
      tally_and_finish();
    end
    // Let key outputs settle on the last evaluation
    repeat (2) @(negedge clk);
  endtask
  // Reset with options, then the calibration scan
  task automatic do_reset(input logic roll, input logic tmo);
    @(negedge clk);
    rst = 1'b1;
    roll_opt = roll;
    tmo_opt = tmo;
    lens = '{16'h0024, 16'h0024, 16'h0024, 16'h0024};
    repeat (12) @(negedge clk);
    check(16'({drive, prechg, xfer, cap_rst, key_out}), 16'h0000);
    last_key = 2'h3;
    cap_prev = 1'b0;
    rst = 1'b0;
    for (int b = 0; b < 5; b++) begin
      wait_bursts(1);
      check(16'(key_out), 16'h0000);
    end
  endtask
  // ==========================================
  // Integration, touch, water and hysteresis on key 0 and key 1
  task automatic test_touch();
    do_reset(1'b1, 1'b1);
    lens[0] = 16'h0002;
    lens[1] = 16'h003C;
    wait_bursts(8);
    lens[0] = 16'h0024;
    wait_bursts(4);
    lens[0] = 16'h0002;
    wait_bursts(8);
    check(16'(key_out), 16'h0000);
    wait_bursts(1);
    check(16'(key_out), 16'h0001);
    check(16'(key_out[1]), 16'h0000);
    lens[0] = 16'h0006;
    wait_bursts(8);
    check(16'(key_out), 16'h0001);
    lens[0] = 16'h000C;
    wait_bursts(4);
    check(16'(key_out), 16'h0000);
    $display("test_touch done");
  endtask
  // Three keys touched together under both rollover settings
  task automatic test_rollover(input logic roll, input logic [3:0] exp);
    do_reset(roll, 1'b1);
    lens[0] = 16'h0002;
    lens[1] = 16'h0002;
    lens[2] = 16'h0002;
    wait_bursts(12);
    check(16'(key_out), 16'(exp));
    $display("test_rollover done");
  endtask
  // Key held on for about 16 s: recalibrates only with the short timeout
  task automatic test_stuck(input logic tmo, input logic [3:0] exp);
    do_reset(1'b1, tmo);
    lens = '{16'h0002, 16'h0008, 16'h0008, 16'h0008};
    wait_bursts(10);
    check(16'(key_out), 16'h0001);
    wait_bursts(20);
    check(16'(key_out), 16'h0001);
    wait_bursts(80);
    check(16'(key_out), 16'(exp));
    $display("test_stuck done");
  endtask
  // Main sequence
  initial begin
    test_touch();
    test_rollover(1'b1, 4'b0011);
    test_rollover(1'b0, 4'b0001);
    test_stuck(1'b0, 4'b0000);
    test_stuck(1'b1, 4'b0001);
    tally_and_finish();
  end
endmodule

/* common/tmkd_pkg.sv */
// Package of constants and types for the touch matrix key detector
package tmkd_pkg;
  localparam int unsigned NUM_KEYS      = 4;
  localparam int unsigned KEY_W         = 2;
  localparam int unsigned BURST_W       = 14;
  localparam logic [13:0] BURST_MAX     = 14'h3FFF;
  localparam int unsigned INTEG_W       = 2;
  localparam logic [1:0]  INTEG_LIMIT   = 2'h3;
  localparam logic [13:0] THRESH_DELTA  = 14'h0020;
  localparam int unsigned HYST_SHIFT    = 2;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned PHASE_NS      = 100;
  localparam int unsigned CLK_NS        = 20;
  localparam int unsigned PHASE_CYC     = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PHASE_W       = 4;
  localparam int unsigned SEC_W         = 26;
  localparam logic [25:0] SEC_CYC       = 26'(CLK_HZ - 1);
  localparam int unsigned STUCK_SHORT_S = 10;
  localparam int unsigned STUCK_LONG_S  = 60;
  localparam int unsigned STUCK_W       = 6;
  typedef enum logic [2:0] {
    TMKD_RESET    = 3'b000,
    TMKD_RST_OPEN = 3'b001,
    TMKD_PRECHG   = 3'b011,
    TMKD_DRIVE_HI = 3'b010,
    TMKD_XFER     = 3'b110,
    TMKD_DRIVE_LO = 3'b111,
    TMKD_EVAL     = 3'b101
  } tmkd_state_t;
endpackage

/* src/tmkd_phase_timer.sv */
// Phase pacing divider: one-cycle tick at the end of each switch phase
`timescale 1ns/1ps
module tmkd_phase_timer #(
  parameter int unsigned WIDTH = 4,
  parameter logic [3:0]  LAST  = 4'h4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  logic [WIDTH-1:0] cnt_r;

  // Count phase cycles, restart on state change
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || tick_o) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Tick depends on the count only, so no loop through the state decode
  assign tick_o = (cnt_r == LAST[WIDTH-1:0]);
endmodule

/* src/tmkd_sec_tick.sv */
// One-second enable divider for stuck-key timers
`timescale 1ns/1ps
module tmkd_sec_tick #(
  parameter int unsigned WIDTH = 26,
  parameter logic [25:0] LAST  = 26'h2FA_F07F
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [WIDTH-1:0] cnt_r;

  // Free running second counter
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_o) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign tick_o = (cnt_r == LAST[WIDTH-1:0]);
endmodule

/* src/tmkd_top.sv */
// Touch matrix key detector: burst sequencer, detection and rollover
// Notes on behaviour
// - Four drive lines, one sense line, keys scanned one at a time.
// - Each acquisition is a burst of transfer cycles on one drive line.
// - Reset switch closes then opens before any other switch acts.
// - Precharge switch closes, then selected drive line goes high.
// - Precharge opens, transfer closes, then drive line goes low.
// - Cycles repeat until capacitor reaches threshold; count is burst length.
// - Calibration stores each key's burst length as its reference.
// - Touch is a burst length decrease relative to reference.
// - Increases in burst length never report a touch.
// - One active-high output per key, high while touched.
// - At most two outputs; first two detected keys keep them.
// - Rollover option can limit detection to a single key.
// - Key stuck on for 10s or 60s recalibrates alone.
// - Rollover input low: one key; high: two keys, rest suppressed.
// - Timeout input low: 10 seconds; high: 60 seconds.
// - Three consecutive detecting samples confirm; any miss clears counter.
// - Release when signal rises 25% of threshold-to-reference distance.
`timescale 1ns/1ps
module tmkd_top #(
  parameter logic [25:0] SEC_LAST = tmkd_pkg::SEC_CYC
) (
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          SYS_RST_I,
  input  wire logic                          CAP_AT_REF_I,
  input  wire logic                          ROLLOVER_OPTION_INPUT_I,
  input  wire logic                          TIMEOUT_OPTION_INPUT_I,
  output logic [tmkd_pkg::NUM_KEYS-1:0]      DRIVE_LINE_O,
  output logic                               PRECHARGE_SWITCH_O,
  output logic                               TRANSFER_SWITCH_O,
  output logic                               CAP_RESET_SWITCH_O,
  output logic [tmkd_pkg::NUM_KEYS-1:0]      KEY_OUT_O
);
  import tmkd_pkg::*;

  // ==========================================================
  // Declarations
  tmkd_state_t               state_r;
  tmkd_state_t               state_nxt;
  logic [KEY_W-1:0]          key_r;
  logic [BURST_W-1:0]        burst_r;
  logic [BURST_W-1:0]        ref_r   [NUM_KEYS];
  logic [INTEG_W-1:0]        integ_r [NUM_KEYS];
  logic [STUCK_W-1:0]        stuck_r [NUM_KEYS];
  logic [NUM_KEYS-1:0]       cal_need_r;
  logic [NUM_KEYS-1:0]       det_r;
  logic [NUM_KEYS-1:0]       sec_seen_r;
  logic                      all_cal_r;
  logic                      phase_tick;
  logic                      sec_tick;
  logic                      burst_done;
  logic [BURST_W-1:0]        cur_ref;
  logic [BURST_W-1:0]        thresh;
  logic [BURST_W-1:0]        release_lvl;
  logic                      below_thr;
  logic                      above_rel;
  logic [2:0]                det_count;
  logic                      slot_free;
  logic [STUCK_W-1:0]        stuck_limit;

  // ==========================================================
  // Pacing dividers
  tmkd_phase_timer #(
    .WIDTH (PHASE_W),
    .LAST  (4'(PHASE_CYC - 1))
  ) u_phase (
    .clk_i     (SYS_CLK_I),
    .rst_i     (SYS_RST_I),
    .restart_i (state_r != state_nxt),
    .tick_o    (phase_tick)
  );

  tmkd_sec_tick #(
    .WIDTH (SEC_W),
    .LAST  (SEC_LAST)
  ) u_sec (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SYS_RST_I),
    .tick_o (sec_tick)
  );

  // ==========================================================
  // Burst sequencer
  assign burst_done = CAP_AT_REF_I || (burst_r == BURST_MAX);

  // Next state of switch sequence
  always_comb begin
    state_nxt = state_r;
    if (phase_tick) begin
      unique case (state_r)
        TMKD_RESET:    state_nxt = TMKD_RST_OPEN;
        TMKD_RST_OPEN: state_nxt = TMKD_PRECHG;
        TMKD_PRECHG:   state_nxt = TMKD_DRIVE_HI;
        TMKD_DRIVE_HI: state_nxt = TMKD_XFER;
        TMKD_XFER:     state_nxt = TMKD_DRIVE_LO;
        TMKD_DRIVE_LO: state_nxt = burst_done ? TMKD_EVAL : TMKD_PRECHG;
        TMKD_EVAL:     state_nxt = TMKD_RESET;
        default:       state_nxt = TMKD_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= TMKD_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Key index advances once per finished burst
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      key_r <= '0;
    end else if (state_r == TMKD_EVAL && phase_tick) begin
      key_r <= key_r + 1'b1;
    end
  end

  // Transfer cycle counter
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || state_r == TMKD_RESET) begin
      burst_r <= '0;
    end else if (state_r == TMKD_DRIVE_LO && phase_tick && burst_r != BURST_MAX) begin
      burst_r <= burst_r + 1'b1;                                      // Counts once per transfer cycle, holding at BURST_MAX
    end
  end

  // Switch and drive outputs from flip-flops
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      CAP_RESET_SWITCH_O <= 1'b0;
      PRECHARGE_SWITCH_O <= 1'b0;
      TRANSFER_SWITCH_O  <= 1'b0;
      DRIVE_LINE_O       <= '0;
    end else begin
      CAP_RESET_SWITCH_O <= (state_nxt == TMKD_RESET);
      PRECHARGE_SWITCH_O <= (state_nxt == TMKD_PRECHG) ||
                            (state_nxt == TMKD_DRIVE_HI);
      TRANSFER_SWITCH_O  <= (state_nxt == TMKD_XFER) ||
                            (state_nxt == TMKD_DRIVE_LO);
      DRIVE_LINE_O       <= '0;
      if (state_nxt == TMKD_DRIVE_HI || state_nxt == TMKD_XFER) begin
        DRIVE_LINE_O[key_r] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Detection levels for the scanned key
  assign cur_ref     = ref_r[key_r];
  assign thresh      = (cur_ref > THRESH_DELTA) ? cur_ref - THRESH_DELTA : '0;
  assign release_lvl = thresh + (THRESH_DELTA >> HYST_SHIFT);
  assign below_thr   = burst_r < thresh;
  assign above_rel   = burst_r >= release_lvl;
  assign det_count   = 3'(det_r[0]) + 3'(det_r[1]) + 3'(det_r[2]) + 3'(det_r[3]);
  assign slot_free   = ROLLOVER_OPTION_INPUT_I ? (det_count < 3'h2)
                                               : (det_count == 3'h0);
  assign stuck_limit = TIMEOUT_OPTION_INPUT_I ? STUCK_W'(STUCK_LONG_S)
                                              : STUCK_W'(STUCK_SHORT_S);

  // Per-key evaluation at end of burst
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      cal_need_r <= '1;
      det_r      <= '0;
      for (int k = 0; k < NUM_KEYS; k++) begin
        ref_r[k]   <= '0;
        integ_r[k] <= '0;
        stuck_r[k] <= '0;
      end
    end else if (state_r == TMKD_EVAL && phase_tick) begin
      if (cal_need_r[key_r]) begin
        ref_r[key_r]      <= burst_r;
        cal_need_r[key_r] <= 1'b0;
        integ_r[key_r]    <= '0;
        stuck_r[key_r]    <= '0;
        det_r[key_r]      <= 1'b0;
      end else if (det_r[key_r]) begin
        if (above_rel) begin
          det_r[key_r]   <= 1'b0;
          stuck_r[key_r] <= '0;
        end else if (stuck_r[key_r] >= stuck_limit) begin
          cal_need_r[key_r] <= 1'b1;
        end else if (sec_seen_r[key_r]) begin
          stuck_r[key_r] <= stuck_r[key_r] + 1'b1;
        end
      end else if (below_thr && slot_free) begin
        if (integ_r[key_r] == INTEG_LIMIT - 1'b1) begin
          det_r[key_r]   <= 1'b1;
          integ_r[key_r] <= '0;
        end else begin
          integ_r[key_r] <= integ_r[key_r] + 1'b1;
        end
      end else begin
        integ_r[key_r] <= '0;
      end
    end
  end

  // Second ticks held per key until that key is next scanned
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sec_seen_r <= '0;
    end else begin
      for (int k = 0; k < NUM_KEYS; k++) begin
        if (sec_tick) begin
          sec_seen_r[k] <= 1'b1;
        end else if (state_r == TMKD_EVAL && phase_tick && key_r == KEY_W'(k)) begin
          sec_seen_r[k] <= 1'b0;
        end
      end
    end
  end

  // Calibration complete flag
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      all_cal_r <= 1'b0;
    end else if (cal_need_r == '0) begin
      all_cal_r <= 1'b1;
    end
  end

  // Key outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      KEY_OUT_O <= '0;
    end else begin
      KEY_OUT_O <= all_cal_r ? det_r : '0;
    end
  end

  // ==========================================================
  // Assertions
  AST_RESET_EXCL: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    CAP_RESET_SWITCH_O |-> !PRECHARGE_SWITCH_O && !TRANSFER_SWITCH_O && DRIVE_LINE_O == '0)
    else $error("Reset switch overlaps another switch");
  AST_ONE_DRIVE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $onehot0(DRIVE_LINE_O))
    else $error("More than one drive line high");
  AST_PRE_XFER: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !(PRECHARGE_SWITCH_O && TRANSFER_SWITCH_O))
    else $error("Precharge and transfer closed together");
  AST_DRIVE_UNDER_PRE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(|DRIVE_LINE_O) |-> PRECHARGE_SWITCH_O)
    else $error("Drive rose without precharge closed");
  AST_DRIVE_FALL: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $fell(|DRIVE_LINE_O) |-> TRANSFER_SWITCH_O)
    else $error("Drive fell outside transfer");
  AST_ROLLOVER: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $countones(det_r) <= 2)
    else $error("More than two keys detected");
  AST_SINGLE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !ROLLOVER_OPTION_INPUT_I && (det_r & ~$past(det_r)) != '0 |-> $countones(det_r) == 1)
    else $error("Second key in single-key mode");
  AST_CAL_GATE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !all_cal_r |=> KEY_OUT_O == '0)
    else $error("Output before calibration");
  AST_NO_RISE_DET: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (det_r & ~$past(det_r)) != '0 |-> $past(below_thr))
    else $error("Detection without decrease");

  // Switch order, drive on the scanned key and burst count steps
  AST_RST_OPEN_FIRST: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(PRECHARGE_SWITCH_O) |-> !$past(CAP_RESET_SWITCH_O))
    else $error("Precharge closed while reset switch closed");
  AST_PRECHG_FIRST: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(|DRIVE_LINE_O) |-> $past(PRECHARGE_SWITCH_O))
    else $error("Drive rose before precharge closed");
  AST_PRE_THEN_XFER: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(TRANSFER_SWITCH_O) |-> $past(PRECHARGE_SWITCH_O))
    else $error("Transfer closed without precharge phase");
  AST_DRIVE_LO_EXIT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $fell(TRANSFER_SWITCH_O) |-> $past(DRIVE_LINE_O) == '0)
    else $error("Transfer opened before drive went low");
  AST_DRIVE_SCANNED: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    DRIVE_LINE_O != '0 |-> DRIVE_LINE_O[key_r])
    else $error("Drive on a key other than the scanned one");
  AST_BURST_STEP: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    burst_r != $past(burst_r) |-> $past(state_r) == TMKD_DRIVE_LO || burst_r == '0)
    else $error("Burst length moved outside a transfer cycle end");

  // Detection and output checks
  AST_SINGLE_LIMIT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !ROLLOVER_OPTION_INPUT_I |-> $countones(det_r) <= 1)
    else $error("More than one key in single-key mode");
  AST_WATER: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (det_r & ~$past(det_r)) != '0 |-> $past(burst_r) < $past(cur_ref))
    else $error("Detection without shorter burst");
  AST_OUT_ONLY_DET: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (KEY_OUT_O & ~$past(det_r)) == '0)
    else $error("Output high for an undetected key");

  // Scenario covers
  COV_DETECT: cover property (@(posedge SYS_CLK_I) $rose(|KEY_OUT_O));
  COV_TWO:    cover property (@(posedge SYS_CLK_I) $countones(KEY_OUT_O) == 2);
  COV_STUCK:  cover property (@(posedge SYS_CLK_I) $rose(|cal_need_r));
  COV_SINGLE: cover property (@(posedge SYS_CLK_I) !ROLLOVER_OPTION_INPUT_I && $rose(|KEY_OUT_O));
  COV_REL:    cover property (@(posedge SYS_CLK_I) $fell(|KEY_OUT_O));
endmodule
